/* File: core/sfr_fifo_mem.sv */
`timescale 1ns/1ps
module sfr_fifo_mem #(
  parameter int W = 256,
  parameter int D = 64
) (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic [W-1:0]         in_data_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  output logic [W-1:0]              out_data_o,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  output logic [$clog2(D+2)-1:0]    level_o
);
  localparam int AW = $clog2(D);
  localparam int LW = $clog2(D+2);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic [W-1:0]  dout;
    logic          dvalid;
  } sfr_fifo_state_type;

  sfr_fifo_state_type s_q;
  sfr_fifo_state_type s_d;
  logic [W-1:0]       mem [D];
  logic               push;
  logic               load;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o  = (s_q.cnt != (AW+1)'(D));
  assign out_data_o  = s_q.dout;
  assign out_valid_o = s_q.dvalid;
  assign level_o     = LW'(s_q.cnt) + LW'(s_q.dvalid);

  always_comb begin
    s_d  = s_q;
    push = in_valid_i && in_ready_o;
    load = (s_q.cnt != '0) && (!s_q.dvalid || out_ready_i);
    if (s_q.dvalid && out_ready_i) begin
      s_d.dvalid = 1'b0;
    end
    if (push) begin
      s_d.wp = next_ptr(s_q.wp);
    end
    if (load) begin
      // read data leave through a register, never straight from the array
      s_d.dout   = mem[s_q.rp];
      s_d.dvalid = 1'b1;
      s_d.rp     = next_ptr(s_q.rp);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[s_q.wp] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* File: core/sfr_streamer.sv */
`timescale 1ns/1ps
module sfr_streamer #(
  parameter int BITS   = sfr_pkg::BITS_DEF,
  parameter int PAR    = sfr_pkg::PAR_DEF,
  parameter int SEQ    = sfr_pkg::SEQ_DEF,
  parameter int MAX_W  = sfr_pkg::MAX_W_DEF,
  parameter int MAX_H  = sfr_pkg::MAX_H_DEF,
  parameter int MW     = sfr_pkg::MW_DEF,
  parameter int DEPTH  = sfr_pkg::DEPTH_DEF,
  parameter int BURST  = sfr_pkg::BURST_DEF
) (
  input  wire logic                          CLOCK_I,
  input  wire logic                          SRST_I,
  input  wire logic                          GO_I,
  input  wire logic                          IRQ_EN_I,
  input  wire logic                          IRQ_CLEAR_I,
  input  wire logic                          FRAME_SEL_I,
  input  wire logic [sfr_pkg::ADDR_W-1:0]    BASE0_ADDR_I,
  input  wire logic [sfr_pkg::ADDR_W-1:0]    BASE1_ADDR_I,
  input  wire logic [sfr_pkg::CNT_W-1:0]     WORDS_I,
  input  wire logic [sfr_pkg::CNT_W-1:0]     PATTERNS_I,
  input  wire logic [sfr_pkg::DIM_W-1:0]     WIDTH_I,
  input  wire logic [sfr_pkg::DIM_W-1:0]     HEIGHT_I,
  input  wire logic [sfr_pkg::ILACE_W-1:0]   INTERLACE_I,
  output logic                               STATUS_O,
  output logic                               IRQ_FLAG_O,
  output logic                               IRQ_O,
  output logic [sfr_pkg::ADDR_W-1:0]         MEM_ADDR_O,
  output logic                               MEM_READ_O,
  output logic [$clog2(BURST+1)-1:0]         MEM_BURST_O,
  input  wire logic [MW-1:0]                 MEM_RDATA_I,
  input  wire logic                          MEM_RVALID_I,
  input  wire logic                          MEM_WAIT_I,
  output logic [BITS*PAR-1:0]                DOUT_DATA_O,
  output logic                               DOUT_VALID_O,
  output logic                               DOUT_SOP_O,
  output logic                               DOUT_EOP_O,
  input  wire logic                          DOUT_READY_I
);
  // ------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------
  // one beat is PAR samples of BITS each; SEQ only tells the sink how
  // many beats make a pixel and so shapes nothing here
  localparam int DW    = BITS * PAR;
  localparam int AW    = sfr_pkg::ADDR_W;
  localparam int CW    = sfr_pkg::CNT_W;
  localparam int BC_W  = $clog2(BURST + 1);
  localparam int LW    = $clog2(DEPTH + 2);
  localparam int NB    = (sfr_pkg::CTRL_NIBBLES + PAR - 1) / PAR;

  // addresses step by one master word per transfer
  localparam logic [AW-1:0]              BYTES  = AW'(MW / 8);
  localparam logic [CW-1:0]              BURSTC = CW'(BURST);
  localparam logic [CW:0]                ROOM   = (CW+1)'(DEPTH);
  localparam logic [sfr_pkg::DIM_W-1:0]  WLIM   = sfr_pkg::DIM_W'(MAX_W);
  localparam logic [sfr_pkg::DIM_W-1:0]  HLIM   = sfr_pkg::DIM_W'(MAX_H);
  localparam logic [sfr_pkg::BEAT_W-1:0] LASTB  = sfr_pkg::BEAT_W'(NB - 1);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    sfr_pkg::sfr_state_type            st;

    logic [AW-1:0]                     next_addr;
    logic [AW-1:0]                     maddr;
    logic                              rd;
    logic [BC_W-1:0]                   burst;
    logic [CW-1:0]                     req_left;
    logic [CW-1:0]                     rx_left;
    logic [CW-1:0]                     outst;
    logic [CW-1:0]                     pat_left;

    logic [sfr_pkg::DIM_W-1:0]         width;
    logic [sfr_pkg::DIM_W-1:0]         height;
    logic [sfr_pkg::ILACE_W-1:0]       ilace;

    logic [sfr_pkg::BEAT_W-1:0]        beat;
    logic [DW-1:0]                     data;
    logic                              valid;
    logic                              sop;
    logic                              eop;

    logic                              flag;
    logic                              irq;
    logic                              busy;
  } sfr_top_state_type;

  sfr_top_state_type s_q;
  sfr_top_state_type s_d;

  logic          fifo_valid;
  logic [MW-1:0] fifo_data;
  logic          unp_in_ready;
  logic          unp_valid;
  logic [DW-1:0] unp_data;
  logic          unp_ready;
  logic [LW-1:0] level;

  logic          can_load;

  logic          accepted;
  logic          issue;
  logic [CW-1:0] len;
  logic [CW:0]   need;

  // ------------------------------------------------------------------
  // control packet nibbles
  // ------------------------------------------------------------------
  function automatic logic [sfr_pkg::NIB_W-1:0] ctrl_nibble(
    input int                          idx,
    input logic [sfr_pkg::DIM_W-1:0]   w,
    input logic [sfr_pkg::DIM_W-1:0]   h,
    input logic [sfr_pkg::ILACE_W-1:0] il
  );
    ctrl_nibble = '0;
    case (idx)
      0: ctrl_nibble = w[15:12];
      1: ctrl_nibble = w[11:8];
      2: ctrl_nibble = w[7:4];
      3: ctrl_nibble = w[3:0];
      4: ctrl_nibble = h[15:12];
      5: ctrl_nibble = h[11:8];
      6: ctrl_nibble = h[7:4];
      7: ctrl_nibble = h[3:0];
      8: ctrl_nibble = il;
      default: ctrl_nibble = '0;
    endcase
  endfunction

  // nibbles are spread over the parallel planes, one per sample, low bits
  function automatic logic [DW-1:0] ctrl_beat(
    input logic [sfr_pkg::BEAT_W-1:0]  b,
    input logic [sfr_pkg::DIM_W-1:0]   w,
    input logic [sfr_pkg::DIM_W-1:0]   h,
    input logic [sfr_pkg::ILACE_W-1:0] il
  );
    ctrl_beat = '0;
    for (int p = 0; p < PAR; p++) begin
      ctrl_beat[p*BITS +: sfr_pkg::NIB_W] = ctrl_nibble(int'(b) * PAR + p, w, h, il);
    end
  endfunction

  // ------------------------------------------------------------------
  // read buffer and word unpacker
  // ------------------------------------------------------------------
  // no ready reaches the memory side: bursts are only issued when the
  // buffer has room for every word still in flight
  sfr_fifo_mem #(
    .W (MW),
    .D (DEPTH)
  ) u_fifo (
    .clk_i       (CLOCK_I),
    .srst_i      (SRST_I),
    .in_data_i   (MEM_RDATA_I),
    .in_valid_i  (MEM_RVALID_I),
    .in_ready_o  (),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (unp_in_ready),
    .level_o     (level)
  );

  // holds one word and hands out its patterns in turn
  sfr_unpack #(
    .MW (MW),
    .PW (DW)
  ) u_unpack (
    .clk_i       (CLOCK_I),
    .srst_i      (SRST_I),
    .in_data_i   (fifo_data),
    .in_valid_i  (fifo_valid),
    .in_ready_o  (unp_in_ready),
    .out_data_o  (unp_data),
    .out_valid_o (unp_valid),
    .out_ready_i (unp_ready)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d       = s_q;
    unp_ready = 1'b0;

    // output register refills only when empty or taken, so a stalled
    // sink simply holds the beat
    can_load  = !s_q.valid || DOUT_READY_I;
    if (s_q.valid && DOUT_READY_I) begin
      s_d.valid = 1'b0;
    end

    // read master: the master shares CLOCK_I; a separate master clock
    // is not offered in this build
    len      = (s_q.req_left < BURSTC) ? s_q.req_left : BURSTC;
    need     = (CW+1)'(level) + {1'b0, s_q.outst}
               + {1'b0, len};
    // the next burst may leave in the cycle the last one is taken
    accepted = s_q.rd && !MEM_WAIT_I;
    issue    = (!s_q.rd || accepted)
               && (s_q.st != sfr_pkg::ST_IDLE)
               && (s_q.req_left != '0) && (need <= ROOM);

    if (accepted) begin
      s_d.rd = 1'b0;
    end
    if (issue) begin
      // ascending addresses, first burst at the sampled base
      s_d.rd        = 1'b1;
      s_d.maddr     = s_q.next_addr;
      s_d.burst     = BC_W'(len);
      s_d.next_addr = s_q.next_addr + AW'(len) * BYTES;
      s_d.req_left  = s_q.req_left - len;
    end

    // words in flight: up on issue, down per returned word
    s_d.outst = s_q.outst + (issue ? len : '0) - CW'(MEM_RVALID_I);
    if (MEM_RVALID_I) begin
      s_d.rx_left = s_q.rx_left - 1'b1;
    end

    // frame sequencer
    case (s_q.st)
      sfr_pkg::ST_IDLE: begin
        s_d.busy = 1'b0;
        if (GO_I) begin
          // frame settings latched here, not the interrupt enable; later writes wait for next frame
          s_d.next_addr = FRAME_SEL_I ? BASE1_ADDR_I : BASE0_ADDR_I;
          s_d.req_left  = WORDS_I;
          s_d.rx_left   = WORDS_I;
          s_d.pat_left  = PATTERNS_I;
          // oversize sizes are clamped, not refused
          s_d.width     = (WIDTH_I > WLIM) ? WLIM : WIDTH_I;
          s_d.height    = (HEIGHT_I > HLIM) ? HLIM : HEIGHT_I;
          s_d.ilace     = INTERLACE_I;
          s_d.busy      = 1'b1;
          s_d.st        = sfr_pkg::ST_CHDR;
        end
      end

      sfr_pkg::ST_CHDR: begin
        if (can_load) begin
          s_d.data  = DW'(sfr_pkg::PKT_CTRL);
          s_d.valid = 1'b1;
          s_d.sop   = 1'b1;
          s_d.eop   = 1'b0;
          s_d.beat  = '0;
          s_d.st    = sfr_pkg::ST_CDATA;
        end
      end

      sfr_pkg::ST_CDATA: begin
        // the last control beat carries EOP
        if (can_load) begin
          s_d.data  = ctrl_beat(s_q.beat, s_q.width, s_q.height, s_q.ilace);
          s_d.valid = 1'b1;
          s_d.sop   = 1'b0;
          s_d.eop   = (s_q.beat == LASTB);
          s_d.beat  = s_q.beat + 1'b1;
          if (s_q.beat == LASTB) begin
            s_d.st = sfr_pkg::ST_VHDR;
          end
        end
      end

      sfr_pkg::ST_VHDR: begin
        // goes first even if words already wait
        if (can_load) begin
          s_d.data  = DW'(sfr_pkg::PKT_VIDEO);
          s_d.valid = 1'b1;
          s_d.sop   = 1'b1;
          s_d.eop   = 1'b0;
          s_d.st    = sfr_pkg::ST_VDATA;
        end
      end

      sfr_pkg::ST_VDATA: begin
        // zero patterns, or too few words for them,
        // stall here for good: a software error
        unp_ready = can_load;
        if (can_load && unp_valid) begin
          s_d.data     = unp_data;
          s_d.valid    = 1'b1;
          s_d.sop      = 1'b0;
          s_d.eop      = (s_q.pat_left == CW'(1));
          s_d.pat_left = s_q.pat_left - 1'b1;
          if (s_q.pat_left == CW'(1)) begin
            s_d.flag = 1'b1;
            s_d.st   = sfr_pkg::ST_DRAIN;
          end
        end
      end

      sfr_pkg::ST_DRAIN: begin
        // surplus patterns and words are swallowed so the next frame
        // starts clean
        // idle is entered only once no word is left in flight or buffered
        unp_ready = 1'b1;
        if (s_q.req_left == '0 && s_q.rx_left == '0 && s_q.outst == '0
            && !s_q.rd && level == '0 && !unp_valid) begin
          s_d.st = sfr_pkg::ST_IDLE;
        end
      end

      default: begin
        s_d.st = sfr_pkg::ST_IDLE;
      end
    endcase

    // clear loses to a completion in the same cycle unless the flag was already set
    if (IRQ_CLEAR_I && !(s_d.flag && !s_q.flag)) begin
      s_d.flag = 1'b0;
    end
    // registered beside the flag, so both rise on one edge
    s_d.irq = s_d.flag && IRQ_EN_I;
  end

  // reset zeroes all state, the idle state included
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // each output is a bare register field
  assign STATUS_O     = s_q.busy;
  assign IRQ_FLAG_O   = s_q.flag;
  assign IRQ_O        = s_q.irq;
  assign MEM_ADDR_O   = s_q.maddr;
  assign MEM_READ_O   = s_q.rd;
  assign MEM_BURST_O  = s_q.burst;
  assign DOUT_DATA_O  = s_q.data;
  assign DOUT_VALID_O = s_q.valid;
  assign DOUT_SOP_O   = s_q.sop;
  assign DOUT_EOP_O   = s_q.eop;
endmodule

/* File: core/sfr_unpack.sv */
`timescale 1ns/1ps
module sfr_unpack #(
  parameter int MW = 256,
  parameter int PW = 24
) (
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic [MW-1:0] in_data_i,
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  output logic [PW-1:0]      out_data_o,
  output logic               out_valid_o,
  input  wire logic          out_ready_i
);
  localparam int PPW = MW / PW;
  localparam int IW  = $clog2(PPW + 1);

  typedef struct packed {
    logic [MW-1:0] word;
    logic [IW-1:0] left;
  } sfr_unpack_state_type;

  sfr_unpack_state_type s_q;
  sfr_unpack_state_type s_d;
  logic                 pop;

  assign out_valid_o = (s_q.left != '0);
  assign out_data_o  = s_q.word[PW-1:0];
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = !out_valid_o || (pop && s_q.left == IW'(1));

  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.word = s_q.word >> PW;
      s_d.left = s_q.left - 1'b1;
    end
    if (in_valid_i && in_ready_o) begin
      // only whole patterns are counted, so unused top bits never leave
      s_d.word = in_data_i;
      s_d.left = IW'(PPW);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* File: shared/sfr_pkg.sv */
// Operation
// - each frame: control packet, then video packet header, then fetched payload
// - control packet width, height, interlace come from configured values
// - bits per colour sample is a build setting 4 to 16, default 8
// - parallel colour planes per beat build setting 1 to 4, default 3
// - planes in sequence 1 to 3, default 3, no effect on beat layout
// - master data width is a build setting 16 to 256, default 256
// - words hold whole patterns only; leftover top bits are ignored
// - patterns leave each word least significant first
// - words are fetched in order from the programmed start address
// - two frame base addresses chosen by one select control
// - frame-completed interrupt fires once per video packet sent
// - frame width limited by build setting 32 to 2600, default 640
// - frame height limited by build setting 32 to 2600, default 480
// - every interlace encoding is passed into the control packet
// - stream may stall; downstream backpressure is tolerated without error
// - fetched words buffer in a FIFO, depth 8 to 1024, default 64
// - read bursts aim at a target length 2 to 256, default 32
// - build option for a separate master clock; not offered here, the master shares CLOCK_I
// - go starts frame output; interrupt enable gates end-of-frame interrupt
// - end-of-frame flag cleared by a write of one
// - configuration is sampled once at each frame start; the interrupt enable is not sampled, IRQ_EN_I acts live
// - select 0 picks frame location 0, select 1 picks location 1
package sfr_pkg;
  localparam int BITS_DEF     = 8;
  localparam int PAR_DEF      = 3;
  localparam int SEQ_DEF      = 3;
  localparam int MAX_W_DEF    = 640;
  localparam int MAX_H_DEF    = 480;
  localparam int MW_DEF       = 256;
  localparam int DEPTH_DEF    = 64;
  localparam int BURST_DEF    = 32;
  localparam int ADDR_W       = 32;
  localparam int CNT_W        = 24;
  localparam int DIM_W        = 16;
  localparam int NIB_W        = 4;
  localparam int ILACE_W      = 4;
  localparam int CTRL_NIBBLES = 9;
  localparam int BEAT_W       = 4;
  localparam logic [3:0] PKT_VIDEO = 4'h0;
  localparam logic [3:0] PKT_CTRL  = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHDR,
    ST_CDATA,
    ST_VHDR,
    ST_VDATA,
    ST_DRAIN
  } sfr_state_type;
endpackage

/* File: tb/sfr_mem_model.sv */
`timescale 1ns/1ps
module sfr_mem_model #(
  parameter int BW = 3
) (
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic          slow_i,
  input  wire logic [31:0]   addr_i,
  input  wire logic          read_i,
  input  wire logic [BW-1:0] burst_i,
  output logic               wait_o,
  output logic               rvalid_o,
  output logic [63:0]        rdata_o
);
  // ----------------------------------------------------------------
  // burst fabric: words are answered in request order
  // ----------------------------------------------------------------
  logic [31:0] pend_q[$];
  logic        tick = 1'b0;

  initial begin
    wait_o = 1'b0;
    rvalid_o = 1'b0;
    rdata_o = 64'h0;
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      pend_q.delete();
    end else if (read_i && !wait_o) begin
      for (int i = 0; i < burst_i; i++) begin
        pend_q.push_back(addr_i + 32'(8 * i));
      end
    end
  end

  // slow mode stalls requests and spaces out returned words
  always @(negedge clk_i) begin
    tick = ~tick;
    wait_o = slow_i && !tick;
    if (pend_q.size() > 0 && (!slow_i || tick)) begin
      rvalid_o = 1'b1;
      // junk in the top bits must never reach the stream
      rdata_o = {16'hffff, 8'h01, pend_q[0][15:0], 8'h00, pend_q[0][15:0]};
      pend_q.pop_front();
    end else begin
      rvalid_o = 1'b0;
      rdata_o = ~rdata_o;
    end
  end
endmodule

/* File: tb/sfr_streamer_sva.sv */
`timescale 1ns/1ps
module sfr_streamer_sva #(
  parameter int BITS  = 8,
  parameter int PAR   = 3,
  parameter int BURST = 32
) (
  input wire logic                         CLOCK_I,
  input wire logic                         SRST_I,
  input wire logic                         IRQ_EN_I,
  input wire logic                         IRQ_CLEAR_I,
  input wire logic                         FRAME_SEL_I,
  input wire logic [sfr_pkg::ADDR_W-1:0]   BASE0_ADDR_I,
  input wire logic [sfr_pkg::ADDR_W-1:0]   BASE1_ADDR_I,
  input wire logic                         STATUS_O,
  input wire logic                         IRQ_FLAG_O,
  input wire logic                         IRQ_O,
  input wire logic [sfr_pkg::ADDR_W-1:0]   MEM_ADDR_O,
  input wire logic                         MEM_READ_O,
  input wire logic [$clog2(BURST+1)-1:0]   MEM_BURST_O,
  input wire logic                         MEM_WAIT_I,
  input wire logic [BITS*PAR-1:0]          DOUT_DATA_O,
  input wire logic                         DOUT_VALID_O,
  input wire logic                         DOUT_SOP_O,
  input wire logic                         DOUT_EOP_O,
  input wire logic                         DOUT_READY_I
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);

  chk_req_hold: assert property (
    MEM_READ_O && MEM_WAIT_I |=> MEM_READ_O && $stable(MEM_ADDR_O) && $stable(MEM_BURST_O))
    else $error("read request changed while waiting");
  chk_burst_len: assert property (
    MEM_READ_O |-> MEM_BURST_O != 0 && MEM_BURST_O <= BURST)
    else $error("burst length out of range");
  chk_beat_hold: assert property (
    DOUT_VALID_O && !DOUT_READY_I |=> DOUT_VALID_O && $stable(DOUT_DATA_O)
      && $stable(DOUT_SOP_O) && $stable(DOUT_EOP_O))
    else $error("stalled beat changed");
  chk_sop_after_eop: assert property (
    DOUT_VALID_O && DOUT_READY_I && DOUT_EOP_O |=> !DOUT_VALID_O || DOUT_SOP_O)
    else $error("packet did not restart with start flag");
  chk_flag_on_eop: assert property (
    $rose(IRQ_FLAG_O) |-> DOUT_VALID_O && DOUT_EOP_O && !DOUT_SOP_O)
    else $error("frame flag rose away from packet end");
  chk_irq_follow: assert property (
    IRQ_EN_I |=> IRQ_O == IRQ_FLAG_O)
    else $error("enabled flag did not reach interrupt");
  chk_irq_mask: assert property (
    !IRQ_EN_I |=> !IRQ_O)
    else $error("interrupt without enabled flag");
  chk_flag_clear: assert property (
    IRQ_CLEAR_I && !STATUS_O |=> !IRQ_FLAG_O)
    else $error("flag not cleared");
  chk_first_read: assert property (
    $rose(STATUS_O) |=> MEM_READ_O && MEM_ADDR_O ==
      ($past(FRAME_SEL_I, 2) ? $past(BASE1_ADDR_I, 2) : $past(BASE0_ADDR_I, 2)))
    else $error("first read not at selected base");
  chk_ctrl_first: assert property (
    $rose(STATUS_O) |=> DOUT_VALID_O && DOUT_SOP_O && DOUT_DATA_O[3:0] == 4'hf)
    else $error("frame did not open with control header");
  chk_idle_quiet: assert property (
    !STATUS_O |-> !MEM_READ_O)
    else $error("read issued while idle");
endmodule

bind sfr_streamer sfr_streamer_sva #(.BITS(BITS), .PAR(PAR), .BURST(BURST)) i_sfr_streamer_sva (
  .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .IRQ_EN_I(IRQ_EN_I), .IRQ_CLEAR_I(IRQ_CLEAR_I),
  .FRAME_SEL_I(FRAME_SEL_I), .BASE0_ADDR_I(BASE0_ADDR_I), .BASE1_ADDR_I(BASE1_ADDR_I),
  .STATUS_O(STATUS_O), .IRQ_FLAG_O(IRQ_FLAG_O), .IRQ_O(IRQ_O), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_READ_O(MEM_READ_O), .MEM_BURST_O(MEM_BURST_O), .MEM_WAIT_I(MEM_WAIT_I),
  .DOUT_DATA_O(DOUT_DATA_O), .DOUT_VALID_O(DOUT_VALID_O), .DOUT_SOP_O(DOUT_SOP_O),
  .DOUT_EOP_O(DOUT_EOP_O), .DOUT_READY_I(DOUT_READY_I));

/* File: tb/test_memory_frame_streamer.sv */
`timescale 1ns/1ps
module test_memory_frame_streamer;
  localparam int          BURST = 4;
  localparam logic [31:0] BASE0 = 32'h00010000;
  localparam logic [31:0] BASE1 = 32'h00024000;
  logic        clk = 1'b0, srst = 1'b1, go = 1'b0, irq_en = 1'b0, irq_clear = 1'b0;
  logic        frame_sel = 1'b0, slow = 1'b0, dout_ready = 1'b1;
  logic [23:0] words = 24'h0, patterns = 24'h0;
  logic [15:0] width = 16'h0, height = 16'h0;
  logic [3:0]  interlace = 4'h0;
  logic        status, irq_flag, irq, mem_read, mem_rvalid, mem_wait;
  logic        dout_valid, dout_sop, dout_eop;
  logic [31:0] mem_addr;
  logic [2:0]  mem_burst;
  logic [63:0] mem_rdata;
  logic [23:0] dout_data;
  int          miscompares = 0, total_checks = 0;

  sfr_streamer #(.BITS(8), .PAR(3), .MW(64), .DEPTH(8), .BURST(BURST)) i_sfr_streamer (
    .CLOCK_I(clk), .SRST_I(srst), .GO_I(go), .IRQ_EN_I(irq_en), .IRQ_CLEAR_I(irq_clear),
    .FRAME_SEL_I(frame_sel), .BASE0_ADDR_I(BASE0), .BASE1_ADDR_I(BASE1), .WORDS_I(words),
    .PATTERNS_I(patterns), .WIDTH_I(width), .HEIGHT_I(height), .INTERLACE_I(interlace),
    .STATUS_O(status), .IRQ_FLAG_O(irq_flag), .IRQ_O(irq), .MEM_ADDR_O(mem_addr),
    .MEM_READ_O(mem_read), .MEM_BURST_O(mem_burst), .MEM_RDATA_I(mem_rdata),
    .MEM_RVALID_I(mem_rvalid), .MEM_WAIT_I(mem_wait), .DOUT_DATA_O(dout_data),
    .DOUT_VALID_O(dout_valid), .DOUT_SOP_O(dout_sop), .DOUT_EOP_O(dout_eop),
    .DOUT_READY_I(dout_ready));

  sfr_mem_model #(.BW(3)) i_sfr_mem_model (
    .clk_i(clk), .srst_i(srst), .slow_i(slow), .addr_i(mem_addr), .read_i(mem_read),
    .burst_i(mem_burst), .wait_o(mem_wait), .rvalid_o(mem_rvalid), .rdata_o(mem_rdata));

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // checking and frame driver
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // entered and left at a falling edge; go is dropped so exactly one frame runs
  task automatic run_frame(input logic sel, input logic [15:0] w, input logic [15:0] h,
      input logic [3:0] il, input int nw, input int np, input logic en, input logic st);
    logic [15:0] we;
    logic [15:0] he;
    logic [35:0] nib;
    logic [31:0] exp;
    logic [31:0] adr;
    int          k;
    int          t;
    int          extra;
    we = (w > 16'h0280) ? 16'h0280 : w;
    he = (h > 16'h01e0) ? 16'h01e0 : h;
    nib = {il, he[3:0], he[7:4], he[11:8], he[15:12], we[3:0], we[7:4], we[11:8], we[15:12]};
    frame_sel = sel;
    width = w;
    height = h;
    interlace = il;
    words = 24'(nw);
    patterns = 24'(np);
    irq_en = en;
    slow = st;
    go = 1'b1;
    t = 0;
    while (status !== 1'b1 && t < 50) begin
      @(negedge clk);
      t++;
    end
    go = 1'b0;
    width = ~w;
    frame_sel = ~sel;
    k = 0;
    t = 0;
    extra = 0;
    while (k < np + 5 && t < 3000) begin
      dout_ready = !st || (t % 3 != 0);
      if (dout_valid === 1'b1 && dout_ready) begin
        exp = 32'h0;
        if (k == 0) exp[3:0] = 4'hf;
        for (int p = 0; p < 3 && k > 0 && k < 4; p++) exp[p*8+:8] = {4'h0, nib[((k-1)*3+p)*4+:4]};
        adr = (sel ? BASE1 : BASE0) + 32'(8 * ((k - 5) / 2));
        if (k > 4) exp = {15'h0000, 1'(k % 2 == 0), adr[15:0]};
        chk("dout_data", exp, {8'h00, dout_data} & ((k == 0) ? 32'hf : 32'hffffffff));
        chk("dout_sop", (k == 0 || k == 4), dout_sop);
        chk("dout_eop", (k == 3 || k == np + 4), dout_eop);
        if (k == np + 4) chk("irq_flag_at_eop", 1, irq_flag);
        k++;
      end
      @(negedge clk);
      t++;
    end
    dout_ready = 1'b1;
    chk("beat_count", np + 5, k);
    chk("irq_out", en, irq);
    t = 0;
    while (status === 1'b1 && t < 200) begin
      if (dout_valid === 1'b1) extra++;
      @(negedge clk);
      t++;
    end
    chk("surplus_beats", 0, extra);
    chk("status_idle", 0, status);
    chk("irq_flag_held", 1, irq_flag);
    irq_clear = 1'b1;
    @(negedge clk);
    irq_clear = 1'b0;
    chk("irq_flag_cleared", 0, irq_flag);
    @(negedge clk);
    chk("irq_cleared", 0, irq);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_interlace;
    for (int i = 0; i < 16; i++) begin
      run_frame(i[0], 16'h0123 + 16'(i), 16'h0045, 4'(i), 3, 5, i[1], i[2]);
    end
    $display("test_interlace done");
  endtask

  task test_clamp;
    run_frame(1'b1, 16'hffff, 16'h01e1, 4'h9, 2, 4, 1'b1, 1'b0);
    $display("test_clamp done");
  endtask

  // more words than the buffer holds, slow memory and a stalling sink
  task test_stall;
    run_frame(1'b0, 16'h0280, 16'h01e0, 4'h3, 9, 17, 1'b1, 1'b1);
    $display("test_stall done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    test_interlace();
    test_clamp();
    test_stall();
    report_and_stop();
  end

  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule
